//--- rtl/rcf_reset_cause.sv
// reset cause flags, start-up clock select and system reset sequencer
// Function
// - trap conflict sets bit 15; only power-on or software clears it
// - illegal opcode, address mode or uninitialised pointer sets bit 14
// - deep-sleep flag bit 10 set by sleep with enable; software only clears
// - configuration mismatch reset sets bit 9; power-on clears it
// - bit 8 keeps program memory powered in sleep when one
// - master clear pin reset sets bit 7; power-on clears it
// - reset instruction sets bit 6; power-on clears it
// - bit 5 is a plain software watchdog enable
// - watchdog fuse at one keeps the watchdog enabled regardless
// - watchdog time-out sets bit 4; power-save instruction or power-on clears
// - sleep instruction sets bit 3; power-on clears it
// - idle instruction sets bit 2; power-on clears it
// - brown-out and every power-on set bit 1; no hardware clear
// - power-on sets bit 0; only software clears it
// - software may set or clear any flag but bit 10 (clear only) without causing a reset
// - switching enabled: power-on and brown-out take new oscillator field
// - switching enabled others keep current field; disabled all take config
// - system reset released after reset delay; power-on first adds power-on and power-up delays, brown-out the power-up delay
// - code runs only after reset delay and clock delays both end
// - clock fail monitor starts only after system reset release
// - each reset sets its flag; power-on clears all but bits 1:0
// - any active reset source asserts the system reset
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ns
module rcf_reset_cause
	import rcf_pkg::*;
#(
	parameter logic [20:0] P_POWER_UP_TIMER_CYC = RCF_POWER_UP_TIMER_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire rcf_bus_t i_bus,
	input wire rcf_evt_t i_evt,
	input wire logic i_master_clear_pin_n,
	input wire logic i_brownout,
	input wire logic i_deep_sleep_en,
	input wire logic i_watchdog_fuse,
	input wire logic i_clk_switch_en,
	input wire logic [2:0] i_new_osc_config_field,
	input wire logic [2:0] i_current_osc_field,
	input wire logic i_osc_started,
	input wire logic i_pll_locked,
	input wire logic i_clock_fail_monitor_en,
	output logic [15:0] o_rdata,
	output logic o_system_reset_signal,
	output logic o_exec_enable,
	output logic o_watchdog_enabled,
	output logic o_progmem_sleep_power,
	output logic [2:0] o_clk_sel,
	output logic o_clock_fail_monitor_active
);

////////////////////////////////////////////////////////////////////////////////
// declarations

	logic [1:0] pin_sync_reg;
	logic [1:0] bor_sync_reg;
	logic [15:0] flags_reg;
	logic [15:0] flags_next;
	logic [20:0] cnt_reg;
	logic [20:0] cnt_next;
	rcf_state_t state_reg;
	rcf_state_t state_next;
	logic [2:0] clk_sel_next;
	logic [15:0] rdata_next;
	logic pin_act;
	logic bor_act;
	logic rst_src;
	logic sw_wr;
	logic [15:0] hw_set;
	logic [15:0] hw_clr;
	logic [15:0] sw_val;
	logic [15:0] kept;
	logic [15:0] status;
	logic cnt_done;
	logic exec_next;
	logic system_reset_signal_next;

	function automatic logic [20:0] stage_len(input rcf_state_t st,
		input logic [20:0] power_up_timer);
		case (st)
			RCF_ST_POR: stage_len = RCF_TPOR_CYC;
			RCF_ST_POWER_UP_TIMER: stage_len = power_up_timer;
			RCF_ST_RST: stage_len = RCF_TRST_CYC;
			default: stage_len = 21'h000001;
		endcase
	endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

	always_ff @(posedge i_clk) begin
		pin_sync_reg <= {pin_sync_reg[0], ~i_master_clear_pin_n};
		bor_sync_reg <= {bor_sync_reg[0], i_brownout};
	end

	assign pin_act = pin_sync_reg[1];
	assign bor_act = bor_sync_reg[1];

////////////////////////////////////////////////////////////////////////////////
// reset cause flags

	assign rst_src = pin_act | bor_act | i_evt.trap_conflict |
		i_evt.bad_opcode | i_evt.config_mismatch | i_evt.reset_instr |
		i_evt.wdt_timeout;

	assign hw_set = {
		i_evt.trap_conflict,
		i_evt.bad_opcode,
		3'h0,
		i_evt.sleep_instr & i_deep_sleep_en,
		i_evt.config_mismatch,
		1'b0,
		pin_act,
		i_evt.reset_instr,
		1'b0,
		i_evt.wdt_timeout,
		i_evt.sleep_instr,
		i_evt.idle_instr,
		bor_act,
		1'b0
	};

	assign hw_clr = {11'h000, i_evt.sleep_instr | i_evt.idle_instr,
		4'h0};

	assign sw_wr = i_bus.wr && (i_bus.addr == RCF_IDX_RESET_CAUSE);

	// deep-sleep flag can only be cleared by software
	assign sw_val = {i_bus.wdata[15:11],
		i_bus.wdata[RCF_B_DSLEEP] & flags_reg[RCF_B_DSLEEP],
		i_bus.wdata[9:0]};

	assign kept = sw_wr ? sw_val : (flags_reg & ~hw_clr);

	// set after clear: hardware set wins
	assign flags_next = (kept | hw_set) & RCF_IMPL_MASK;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flags_reg <= RCF_POR_VAL;
		end else begin
			flags_reg <= flags_next;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// reset sequencer

	assign cnt_done = (cnt_reg == stage_len(state_reg, P_POWER_UP_TIMER_CYC) - 21'h1);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + 21'h1;
		if (rst_src) begin
			state_next = bor_act ? RCF_ST_POWER_UP_TIMER : RCF_ST_RST;
			cnt_next = 21'h0;
		end else begin
			case (state_reg)
				RCF_ST_POR: begin
					if (cnt_done) begin
						state_next = RCF_ST_POWER_UP_TIMER;
						cnt_next = 21'h0;
					end
				end
				RCF_ST_POWER_UP_TIMER: begin
					if (cnt_done) begin
						state_next = RCF_ST_RST;
						cnt_next = 21'h0;
					end
				end
				RCF_ST_RST: begin
					if (cnt_done) begin
						state_next = RCF_ST_RUN;
						cnt_next = 21'h0;
					end
				end
				RCF_ST_RUN: cnt_next = 21'h0;
				default: begin
					state_next = RCF_ST_RST;
					cnt_next = 21'h0;
				end
			endcase
		end
	end

	assign system_reset_signal_next = (state_next != RCF_ST_RUN);
	assign exec_next = ~system_reset_signal_next & i_osc_started & i_pll_locked;

	// clock source picked by reset type
	assign clk_sel_next = (!rst_src) ? o_clk_sel :
		(!i_clk_switch_en || bor_act) ? i_new_osc_config_field :
		i_current_osc_field;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= RCF_ST_POR;
			cnt_reg <= 21'h0;
			o_system_reset_signal <= 1'b1;
			o_exec_enable <= 1'b0;
			o_clock_fail_monitor_active <= 1'b0;
			o_clk_sel <= i_new_osc_config_field;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			o_system_reset_signal <= system_reset_signal_next;
			o_exec_enable <= exec_next;
			o_clock_fail_monitor_active <= i_clock_fail_monitor_en &
				~system_reset_signal_next;
			o_clk_sel <= clk_sel_next;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// control outputs and register read

	assign status = {9'h000, o_clk_sel, o_watchdog_enabled,
		o_clock_fail_monitor_active, o_exec_enable, o_system_reset_signal};

	assign rdata_next = !i_bus.rd ? 16'h0000 :
		(i_bus.addr == RCF_IDX_RESET_CAUSE) ? flags_reg :
		(i_bus.addr == RCF_IDX_SEQ_STATUS) ? status : 16'h0000;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
			o_watchdog_enabled <= 1'b0;
			o_progmem_sleep_power <= 1'b0;
		end else begin
			o_rdata <= rdata_next;
			o_watchdog_enabled <= i_watchdog_fuse |
				flags_next[RCF_B_SOFT_WATCHDOG_ENABLE];
			o_progmem_sleep_power <= flags_next[RCF_B_PROGMEM_SLEEP_POWER];
		end
	end

////////////////////////////////////////////////////////////////////////////////
// assertions

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_por_flag_value: assert property (
		$fell(i_rst) |-> flags_reg == RCF_POR_VAL)
		else $error("flags wrong after power-on reset");

	a_trap_flag_set: assert property (
		i_evt.trap_conflict |=> flags_reg[RCF_B_TRAP])
		else $error("trap flag not set");

	a_badop_flag_set: assert property (
		i_evt.bad_opcode |=> flags_reg[RCF_B_BADOP])
		else $error("bad opcode flag not set");

	a_dsleep_rise_cause: assert property (
		$rose(flags_reg[RCF_B_DSLEEP]) |->
		$past(i_evt.sleep_instr && i_deep_sleep_en))
		else $error("deep-sleep flag set without cause");

	a_unimpl_bits_zero: assert property (
		flags_reg[13:11] == 3'h0)
		else $error("unimplemented bits not zero");

	a_wdt_set_wins: assert property (
		(i_evt.wdt_timeout && sw_wr && !i_bus.wdata[RCF_B_WATCHDOG_TIMEOUT_FLAG])
		|=> flags_reg[RCF_B_WATCHDOG_TIMEOUT_FLAG])
		else $error("software clear beat watchdog set");

	a_wdt_fuse_forces: assert property (
		i_watchdog_fuse ##1 i_watchdog_fuse |-> o_watchdog_enabled)
		else $error("watchdog not forced on by fuse");

	a_reset_src_holds: assert property (
		rst_src |=> o_system_reset_signal)
		else $error("reset source did not assert system reset");

	a_release_after_rst: assert property (
		$fell(o_system_reset_signal) |-> $past(state_reg == RCF_ST_RST, 2))
		else $error("system reset released outside reset stage");

	a_exec_gated: assert property (
		o_exec_enable |-> !o_system_reset_signal &&
		$past(i_osc_started && i_pll_locked))
		else $error("execution enabled too early");

	a_clock_fail_monitor_after_rst: assert property (
		o_clock_fail_monitor_active |-> !o_system_reset_signal)
		else $error("clock monitor active during reset");

	a_por_clk_pick: assert property (
		$fell(i_rst) |-> o_clk_sel == $past(i_new_osc_config_field))
		else $error("power-on clock select wrong");

	a_cmism_flag_set: assert property (
		i_evt.config_mismatch |=> flags_reg[RCF_B_CMISM])
		else $error("config mismatch flag not set");

	a_pin_flag_set: assert property (
		pin_act |=> flags_reg[RCF_B_PINRST])
		else $error("pin reset flag not set");

	a_instr_flag_set: assert property (
		i_evt.reset_instr |=> flags_reg[RCF_B_INSTR])
		else $error("reset instruction flag not set");

	a_watchdog_timeout_flag_flag_set: assert property (
		i_evt.wdt_timeout |=> flags_reg[RCF_B_WATCHDOG_TIMEOUT_FLAG])
		else $error("watchdog time-out flag not set");

	a_watchdog_timeout_flag_psave_clr: assert property (
		(i_evt.sleep_instr || i_evt.idle_instr) && !i_evt.wdt_timeout &&
		!sw_wr |=> !flags_reg[RCF_B_WATCHDOG_TIMEOUT_FLAG])
		else $error("power-save did not clear time-out flag");

	a_sleep_flag_set: assert property (
		i_evt.sleep_instr |=> flags_reg[RCF_B_SLEEP])
		else $error("sleep flag not set");

	a_idle_flag_set: assert property (
		i_evt.idle_instr |=> flags_reg[RCF_B_IDLE])
		else $error("idle flag not set");

	a_bor_flag_set: assert property (
		bor_act |=> flags_reg[RCF_B_BOR])
		else $error("brown-out flag not set");

	a_por_flag_sticky: assert property (
		!sw_wr |=> flags_reg[RCF_B_POR] == $past(flags_reg[RCF_B_POR]))
		else $error("power-on flag changed without software");

	a_sw_no_reset: assert property (
		sw_wr && !rst_src && state_reg == RCF_ST_RUN
		|=> !o_system_reset_signal)
		else $error("software write caused a reset");

	a_pms_copy: assert property (
		o_progmem_sleep_power == flags_reg[RCF_B_PROGMEM_SLEEP_POWER])
		else $error("program memory sleep output wrong");

	a_clk_keep_cur: assert property (
		rst_src && i_clk_switch_en && !bor_act
		|=> o_clk_sel == $past(i_current_osc_field))
		else $error("current clock source not kept");

	a_clk_no_switch: assert property (
		rst_src && !i_clk_switch_en
		|=> o_clk_sel == $past(i_new_osc_config_field))
		else $error("configured clock source not taken");

	c_por_release: cover property ($fell(o_system_reset_signal));
	c_bor_reset: cover property ($rose(bor_act));
	c_pin_reset: cover property (pin_act ##1 !pin_act);
	c_dsleep_set: cover property ($rose(flags_reg[RCF_B_DSLEEP]));
	c_exec_start: cover property ($rose(o_exec_enable));

endmodule // rcf_reset_cause

//--- rtl/rcf_pkg.sv
// package: constants and types for the reset cause and clock select block
package rcf_pkg;

	// register bus
	localparam int RCF_ADDR_W = 4;
	localparam int RCF_DATA_W = 16;
	localparam logic [3:0] RCF_IDX_RESET_CAUSE = 4'h0;
	localparam logic [3:0] RCF_IDX_SEQ_STATUS = 4'h1;

	// reset cause control field positions
	localparam int RCF_B_TRAP = 15;
	localparam int RCF_B_BADOP = 14;
	localparam int RCF_B_DSLEEP = 10;
	localparam int RCF_B_CMISM = 9;
	localparam int RCF_B_PROGMEM_SLEEP_POWER = 8;
	localparam int RCF_B_PINRST = 7;
	localparam int RCF_B_INSTR = 6;
	localparam int RCF_B_SOFT_WATCHDOG_ENABLE = 5;
	localparam int RCF_B_WATCHDOG_TIMEOUT_FLAG = 4;
	localparam int RCF_B_SLEEP = 3;
	localparam int RCF_B_IDLE = 2;
	localparam int RCF_B_BOR = 1;
	localparam int RCF_B_POR = 0;

	// reset values and masks
	localparam logic [15:0] RCF_POR_VAL = 16'h0003;
	localparam logic [15:0] RCF_IMPL_MASK = 16'hc7ff;

	// sequence status field positions
	localparam int RCF_S_SYSTEM_RESET_SIGNAL = 0;
	localparam int RCF_S_EXEC = 1;
	localparam int RCF_S_CLOCK_FAIL_MONITOR = 2;
	localparam int RCF_S_WDTEN = 3;
	localparam int RCF_S_CLK_LO = 4;

	// timing
	localparam int RCF_CLK_PERIOD_NS = 50;
	localparam int RCF_CLK_MHZ = 20;
	localparam int RCF_TPOR_NS = 10000;
	localparam int RCF_TRST_NS = 1000;
	localparam int RCF_POWER_UP_TIMER_US = 64000;
	localparam int RCF_CNT_W = 21;
	localparam logic [20:0] RCF_TPOR_CYC = 21'((RCF_TPOR_NS +
		RCF_CLK_PERIOD_NS - 1) / RCF_CLK_PERIOD_NS);
	localparam logic [20:0] RCF_TRST_CYC = 21'((RCF_TRST_NS +
		RCF_CLK_PERIOD_NS - 1) / RCF_CLK_PERIOD_NS);
	localparam logic [20:0] RCF_POWER_UP_TIMER_CYC = 21'(RCF_POWER_UP_TIMER_US * RCF_CLK_MHZ);

	typedef enum {
		RCF_ST_POR,
		RCF_ST_POWER_UP_TIMER,
		RCF_ST_RST,
		RCF_ST_RUN
	} rcf_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} rcf_bus_t;

	typedef struct packed {
		logic trap_conflict;
		logic bad_opcode;
		logic config_mismatch;
		logic reset_instr;
		logic wdt_timeout;
		logic sleep_instr;
		logic idle_instr;
	} rcf_evt_t;

endpackage

//--- dv/rcf_reset_cause_bench.sv
// testbench for the reset cause flags and clock select block
`timescale 1ns/1ns
module rcf_reset_cause_bench;
	import rcf_pkg::*;
	logic i_clk;
	logic i_rst;
	rcf_bus_t bus;
	rcf_evt_t evt;
	logic pin_n, bo, dsen, fuse, swen, osc, pll, fen;
	logic [2:0] newf, curf, csel;
	logic [15:0] rdata, v;
	logic system_reset_signal, exec, wden, pms, fsa;
	int num_errors = 0;
	int n_checks = 0;
	int n;
	logic [15:0] exp_tab [7] = '{16'h0004, 16'h0008, 16'h0010, 16'h0040,
		16'h0200, 16'h4000, 16'h8000};

	rcf_reset_cause #(.P_POWER_UP_TIMER_CYC(21'h00000a)) DUT (
		.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .i_evt(evt),
		.i_master_clear_pin_n(pin_n), .i_brownout(bo),
		.i_deep_sleep_en(dsen), .i_watchdog_fuse(fuse),
		.i_clk_switch_en(swen), .i_new_osc_config_field(newf),
		.i_current_osc_field(curf), .i_osc_started(osc),
		.i_pll_locked(pll), .i_clock_fail_monitor_en(fen),
		.o_rdata(rdata), .o_system_reset_signal(system_reset_signal),
		.o_exec_enable(exec), .o_watchdog_enabled(wden),
		.o_progmem_sleep_power(pms), .o_clk_sel(csel),
		.o_clock_fail_monitor_active(fsa));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic pulse(input int b);
		@(posedge i_clk);
		evt <= 7'(1 << b);
		@(posedge i_clk);
		evt <= '0;
	endtask

	task automatic wait_rel(input int lim);
		#1 n = 0;
		while (system_reset_signal !== 1'b0) begin
			@(posedge i_clk);
			n++;
			if (n > lim) begin
				num_errors++;
				$display("BAD %0t reset never released", $time);
				end_of_test();
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		i_rst = 1'b1;
		bus = '0;
		evt = '0;
		pin_n = 1'b1;
		bo = 1'b0;
		dsen = 1'b0;
		fuse = 1'b0;
		swen = 1'b1;
		osc = 1'b1;
		pll = 1'b1;
		fen = 1'b1;
		newf = 3'h5;
		curf = 3'h2;
		repeat (4) @(posedge i_clk);
		chk1(system_reset_signal, 1'b1);
		chk1(fsa, 1'b0);
		i_rst <= 1'b0;
		rd(4'h0, v);
		chk16(v, 16'h0003);
		wait_rel(400);
		chk1(n >= 210, 1'b1);
		repeat (2) @(posedge i_clk);
		#1 chk1(exec, 1'b1);
		chk1(fsa, 1'b1);
		chk16({13'h0000, csel}, 16'h0005);
		@(posedge i_clk);
		pll <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1 chk1(exec, 1'b0);
		@(posedge i_clk);
		pll <= 1'b1;
		wr(4'h0, 16'hffff);
		rd(4'h0, v);
		chk16(v, 16'hc3ff);
		chk1(system_reset_signal, 1'b0);
		chk1(pms, 1'b1);
		chk1(wden, 1'b1);
		wr(4'h0, 16'h0000);
		rd(4'h0, v);
		chk16(v, 16'h0000);
		chk1(pms, 1'b0);
		chk1(wden, 1'b0);
		@(posedge i_clk);
		fuse <= 1'b1;
		wr(4'h7, 16'hffff);
		wr(4'h1, 16'hffff);
		rd(4'h7, v);
		chk16(v, 16'h0000);
		chk1(wden, 1'b1);
		rd(4'h1, v);
		chk16(v, 16'h005e);
		rd(4'h0, v);
		chk16(v, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			pulse(i);
			#1 chk1(system_reset_signal, 1'(i > 1));
			wait_rel(100);
			rd(4'h0, v);
			chk16(v, exp_tab[i]);
			wr(4'h0, 16'h0000);
		end
		chk16({13'h0000, csel}, 16'h0002);
		pulse(2);
		wait_rel(100);
		@(posedge i_clk);
		dsen <= 1'b1;
		pulse(1);
		rd(4'h0, v);
		chk16(v, 16'h0408);
		wr(4'h0, 16'h0000);
		rd(4'h0, v);
		chk16(v, 16'h0000);
		@(posedge i_clk);
		bus <= '{addr: 4'h0, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
		evt <= 7'h0c;
		@(posedge i_clk);
		bus.wr <= 1'b0;
		evt <= '0;
		wait_rel(100);
		rd(4'h0, v);
		chk16(v, 16'h0050);
		wr(4'h0, 16'h0000);
		@(posedge i_clk);
		swen <= 1'b0;
		pin_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		#1 chk1(system_reset_signal, 1'b1);
		@(posedge i_clk);
		pin_n <= 1'b1;
		wait_rel(100);
		rd(4'h0, v);
		chk16(v, 16'h0080);
		chk16({13'h0000, csel}, 16'h0005);
		wr(4'h0, 16'h0000);
		@(posedge i_clk);
		swen <= 1'b1;
		newf <= 3'h1;
		bo <= 1'b1;
		repeat (4) @(posedge i_clk);
		bo <= 1'b0;
		wait_rel(200);
		rd(4'h0, v);
		chk16(v, 16'h0002);
		chk16({13'h0000, csel}, 16'h0001);
		wr(4'h0, 16'hffff);
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(4'h0, v);
		chk16(v, 16'h0003);
		end_of_test();
	end
endmodule // rcf_reset_cause_bench
